// [include/fbr_defs.vh]
/*
 * register offsets, field positions, reset values and mode codes of the
 * fractional sampling-clock generator.
 * assumes it is included by bare name from the logic files.
 */
`ifndef FBR_DEFS_VH
`define FBR_DEFS_VH

`define FBR_OFF_DIV_LOW      3'h0
`define FBR_OFF_DIV_HIGH     3'h1
`define FBR_OFF_DIV_FRAC     3'h2
`define FBR_OFF_MODEM_CTRL   3'h3
`define FBR_OFF_FIFO_CTRL    3'h4
`define FBR_OFF_STATUS       3'h5

`define FBR_RST_DIV_LOW      8'h01
`define FBR_RST_DIV_HIGH     8'h00
`define FBR_RST_DIV_FRAC     8'h00
`define FBR_RST_MODEM_CTRL   8'h00
`define FBR_RST_FIFO_CTRL    8'h00
`define FBR_UNMAPPED_READ    8'h00

`define FBR_MCR_PRESC_BIT    7
`define FBR_FCR_FIFO_EN_BIT  0
`define FBR_FRAC_MSB         3
`define FBR_FRAC_LSB         0
`define FBR_SAMP_MSB         5
`define FBR_SAMP_LSB         4
`define FBR_STAT_IRQ_BIT     0
`define FBR_STAT_TICK_BIT    1

`define FBR_MODE_16X         2'h0
`define FBR_MODE_8X          2'h1
`define FBR_MODE_4X          2'h2
`define FBR_LAST_16X         4'hf
`define FBR_LAST_8X          4'h7
`define FBR_LAST_4X          4'h3
`define FBR_PRESC_LAST       2'h3

`endif

// [logic/fbr_chan.v]
/*
 * one channel's sampling-clock generator: prescaler, fractional divisor
 * and bit-period counter.
 * assumes osc_edge is a one-cycle pulse per oscillator rising edge,
 * already synchronised to clk.
 */
`timescale 1ns/1ps
`include "fbr_defs.vh"

module fbr_chan (
    input  wire        clk,
    input  wire        rst,
    input  wire        osc_edge,
    input  wire        presc_div4,
    input  wire [15:0] divisor_int,
    input  wire [3:0]  divisor_frac,
    input  wire [1:0]  sample_mode,
    output reg         sample_tick,
    output reg         bit_tick
);
    reg  [1:0]  pre_cnt;
    reg  [16:0] div_cnt;
    reg  [3:0]  frac_acc;
    reg         stretch;
    reg  [3:0]  bit_cnt;
    wire        pre_tick;
    wire [16:0] period_len;
    wire [16:0] next_div_cnt;
    wire [4:0]  next_frac_sum;

    function [3:0] last_sample;
        input [1:0] mode;
        begin
            case (mode)
                `FBR_MODE_8X: last_sample = `FBR_LAST_8X;
                `FBR_MODE_4X: last_sample = `FBR_LAST_4X;
                default:      last_sample = `FBR_LAST_16X;
            endcase
        end
    endfunction

    // prescaler passes every edge or every fourth
    assign pre_tick = osc_edge & (~presc_div4 | (pre_cnt == `FBR_PRESC_LAST));

    // zero integer part (id readback setting) behaves as one
    assign period_len = ((divisor_int == 16'h0000) ? 17'h00001 : {1'b0, divisor_int})
                        + {16'h0000, stretch};
    assign next_div_cnt  = div_cnt + 17'h00001;
    // the fraction accumulates per period; a carry stretches the next period
    assign next_frac_sum = {1'b0, frac_acc} + {1'b0, divisor_frac};

    always @(posedge clk) begin
        if (rst) begin
            pre_cnt     <= 2'h0;
            div_cnt     <= 17'h00000;
            frac_acc    <= 4'h0;
            stretch     <= 1'b0;
            sample_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            if (osc_edge) begin
                pre_cnt <= presc_div4 ? pre_cnt + 2'h1 : 2'h0;
            end
            if (pre_tick) begin
                // >= so a divisor lowered mid-period ends that period at once
                if (next_div_cnt >= period_len) begin
                    div_cnt     <= 17'h00000;
                    sample_tick <= 1'b1;
                    frac_acc    <= next_frac_sum[3:0];
                    stretch     <= next_frac_sum[4];
                end else begin
                    div_cnt <= next_div_cnt;
                end
            end
        end
    end

    // bit period of 16, 8 or 4 sampling periods
    always @(posedge clk) begin
        if (rst) begin
            bit_cnt  <= 4'h0;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (sample_tick) begin
                if (bit_cnt >= last_sample(sample_mode)) begin
                    bit_cnt  <= 4'h0;
                    bit_tick <= 1'b1;
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
        end
    end
endmodule // fbr_chan

// [logic/fbr_top.v]
/*
 * dual-channel fractional sampling-clock generator with its host register
 * port and the two channel interrupt pins.
 * assumes the host bus pins and the oscillator pin are asynchronous to clk;
 * fifo level flags come from logic on clk. oscillator must stay below clk/4.
 */
`timescale 1ns/1ps
`include "fbr_defs.vh"

module fbr_top #(
    parameter [7:0] DEVICE_ID   = 8'h5a, // arbitrary value
    parameter [7:0] REVISION_ID = 8'h01  // arbitrary value
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       chip_select_n,
    input  wire       read_strobe_n,
    input  wire       write_strobe_n,
    input  wire       channel_select,
    input  wire [2:0] addr,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_drive_n,
    input  wire       oscillator_input,
    output reg        oscillator_output,
    input  wire [1:0] tx_below_trigger,
    input  wire [1:0] tx_empty,
    input  wire [1:0] rx_above_trigger,
    output reg        channel_one_interrupt_out,
    output reg        channel_two_interrupt_out,
    output wire       channel_one_sample_tick,
    output wire       channel_one_bit_tick,
    output wire       channel_two_sample_tick,
    output wire       channel_two_bit_tick
);
    // pin bundle: osc, data, addr, chsel, iow, ior, cs
    localparam SYNC_W = 16;

    reg  [SYNC_W-1:0] sync_a;
    reg  [SYNC_W-1:0] sync_b;
    reg  [SYNC_W-1:0] sync_c;
    reg  [SYNC_W-1:0] pins;
    reg               osc_prev;
    reg               write_prev;
    reg  [7:0]        div_low      [0:1];
    reg  [7:0]        div_high     [0:1];
    reg  [7:0]        div_frac     [0:1];
    reg  [7:0]        modem_ctrl   [0:1];
    reg  [7:0]        fifo_ctrl    [0:1];
    reg  [1:0]        tick_seen;
    reg  [7:0]        next_data_out;
    reg  [1:0]        next_irq;
    wire              cs_n_f;
    wire              rd_n_f;
    wire              wr_n_f;
    wire              chsel_f;
    wire [2:0]        addr_f;
    wire [7:0]        data_f;
    wire              osc_f;
    wire              osc_edge;
    wire              write_done;
    wire              ch;
    wire [1:0]        sample_tick;
    wire [1:0]        bit_tick;
    integer           i;
    integer           j;

    function hit;
        input [2:0] a;
        input [2:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // three flops; a level is accepted once the second and third agree
    always @(posedge clk) begin
        if (rst) begin
            sync_a <= {SYNC_W{1'b1}};
            sync_b <= {SYNC_W{1'b1}};
            sync_c <= {SYNC_W{1'b1}};
            pins   <= {SYNC_W{1'b1}};
        end else begin
            sync_a <= {oscillator_input, data_in, addr, channel_select,
                       write_strobe_n, read_strobe_n, chip_select_n};
            sync_b <= sync_a;
            sync_c <= sync_b;
            pins   <= (~(sync_b ^ sync_c) & sync_c) | ((sync_b ^ sync_c) & pins);
        end
    end

    assign cs_n_f  = pins[0];
    assign rd_n_f  = pins[1];
    assign wr_n_f  = pins[2];
    assign chsel_f = pins[3];
    assign addr_f  = pins[6:4];
    assign data_f  = pins[14:7];
    assign osc_f   = pins[15];
    // channel one when select is high
    assign ch      = ~chsel_f;

    always @(posedge clk) begin
        if (rst) begin
            // filter resets high, so the edge detector must too or a false edge follows reset
            osc_prev          <= 1'b1;
            write_prev        <= 1'b1;
            oscillator_output <= 1'b1;
        end else begin
            osc_prev          <= osc_f;
            write_prev        <= wr_n_f;
            oscillator_output <= ~osc_f;
        end
    end

    // oscillator is counted only by the generators, never by the host port
    assign osc_edge   = osc_f & ~osc_prev;
    // write lands on the trailing edge of the strobe, when data is settled
    assign write_done = wr_n_f & ~write_prev & ~cs_n_f;

    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 2; i = i + 1) begin
                div_low[i]    <= `FBR_RST_DIV_LOW;
                div_high[i]   <= `FBR_RST_DIV_HIGH;
                div_frac[i]   <= `FBR_RST_DIV_FRAC;
                modem_ctrl[i] <= `FBR_RST_MODEM_CTRL;
                fifo_ctrl[i]  <= `FBR_RST_FIFO_CTRL;
            end
        end else if (write_done) begin
            if (hit(addr_f, `FBR_OFF_DIV_LOW)) begin
                div_low[ch] <= data_f;
            end
            if (hit(addr_f, `FBR_OFF_DIV_HIGH)) begin
                div_high[ch] <= data_f;
            end
            if (hit(addr_f, `FBR_OFF_DIV_FRAC)) begin
                // only fraction and sampling fields are kept
                div_frac[ch] <= {2'h0, data_f[`FBR_SAMP_MSB:`FBR_SAMP_LSB],
                                 data_f[`FBR_FRAC_MSB:`FBR_FRAC_LSB]};
            end
            if (hit(addr_f, `FBR_OFF_MODEM_CTRL)) begin
                modem_ctrl[ch] <= data_f;
            end
            if (hit(addr_f, `FBR_OFF_FIFO_CTRL)) begin
                fifo_ctrl[ch] <= data_f;
            end
        end
    end

    // shows each generator is alive: flips on every sampling period
    always @(posedge clk) begin
        if (rst) begin
            tick_seen <= 2'h0;
        end else begin
            tick_seen <= tick_seen ^ sample_tick;
        end
    end

    // read mux; a zero integer divisor exposes the id codes
    always @* begin
        next_data_out = `FBR_UNMAPPED_READ;
        if (hit(addr_f, `FBR_OFF_DIV_LOW)) begin
            next_data_out = ({div_high[ch], div_low[ch]} == 16'h0000)
                            ? REVISION_ID : div_low[ch];
        end else if (hit(addr_f, `FBR_OFF_DIV_HIGH)) begin
            next_data_out = ({div_high[ch], div_low[ch]} == 16'h0000)
                            ? DEVICE_ID : div_high[ch];
        end else if (hit(addr_f, `FBR_OFF_DIV_FRAC)) begin
            next_data_out = div_frac[ch];
        end else if (hit(addr_f, `FBR_OFF_MODEM_CTRL)) begin
            next_data_out = modem_ctrl[ch];
        end else if (hit(addr_f, `FBR_OFF_FIFO_CTRL)) begin
            next_data_out = fifo_ctrl[ch];
        end else if (hit(addr_f, `FBR_OFF_STATUS)) begin
            next_data_out = 8'h00;
            next_data_out[`FBR_STAT_IRQ_BIT]  = ch ? channel_two_interrupt_out
                                                   : channel_one_interrupt_out;
            next_data_out[`FBR_STAT_TICK_BIT] = tick_seen[ch];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            data_out     <= 8'h00;
            data_drive_n <= 1'b1;
        end else begin
            data_out     <= next_data_out;
            data_drive_n <= cs_n_f | rd_n_f;
        end
    end

    // fifo disabled: transmitter empty or receive data still raise the pin
    always @* begin
        for (j = 0; j < 2; j = j + 1) begin
            if (fifo_ctrl[j][`FBR_FCR_FIFO_EN_BIT]) begin
                next_irq[j] = tx_below_trigger[j] | tx_empty[j]
                              | rx_above_trigger[j];
            end else begin
                next_irq[j] = tx_empty[j] | rx_above_trigger[j];
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            channel_one_interrupt_out <= 1'b0;
            channel_two_interrupt_out <= 1'b0;
        end else begin
            channel_one_interrupt_out <= next_irq[0];
            channel_two_interrupt_out <= next_irq[1];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            fbr_chan u_gen (
                .clk          (clk),
                .rst          (rst),
                .osc_edge     (osc_edge),
                .presc_div4   (modem_ctrl[g][`FBR_MCR_PRESC_BIT]),
                .divisor_int  ({div_high[g], div_low[g]}),
                .divisor_frac (div_frac[g][`FBR_FRAC_MSB:`FBR_FRAC_LSB]),
                .sample_mode  (div_frac[g][`FBR_SAMP_MSB:`FBR_SAMP_LSB]),
                .sample_tick  (sample_tick[g]),
                .bit_tick     (bit_tick[g])
            );
        end
    endgenerate

    // ticks come straight from the generator flops
    assign channel_one_sample_tick = sample_tick[0];
    assign channel_one_bit_tick    = bit_tick[0];
    assign channel_two_sample_tick = sample_tick[1];
    assign channel_two_bit_tick    = bit_tick[1];
endmodule // fbr_top

// [tb/fbr_chk.sv]
/* pin assertions for the dual sampling-clock generator.
   assumes it is bound to fbr_top, rising edge of clk, rst synchronous high. */
`timescale 1ns/1ps
module fbr_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       chip_select_n,
    input wire logic       read_strobe_n,
    input wire logic       data_drive_n,
    input wire logic       oscillator_input,
    input wire logic       oscillator_output,
    input wire logic [1:0] tx_below_trigger,
    input wire logic [1:0] tx_empty,
    input wire logic [1:0] rx_above_trigger,
    input wire logic       channel_one_interrupt_out,
    input wire logic       channel_two_interrupt_out,
    input wire logic       channel_one_sample_tick,
    input wire logic       channel_one_bit_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // six cycles covers three sync flops, agreement and the output flop
    sequence s_rd_held; (!chip_select_n && !read_strobe_n) [*6]; endsequence
    sequence s_idle; chip_select_n [*6]; endsequence
    sequence s_osc_still; $stable(oscillator_input) [*6]; endsequence
    a_irq_one_set: assert property ((tx_empty[0] || rx_above_trigger[0]) |=> channel_one_interrupt_out)
        else $error("channel one interrupt not raised");
    a_irq_one_clear: assert property (!(tx_below_trigger[0] || tx_empty[0] || rx_above_trigger[0]) |=> !channel_one_interrupt_out)
        else $error("channel one interrupt not cleared");
    a_irq_two_set: assert property ((tx_empty[1] || rx_above_trigger[1]) |=> channel_two_interrupt_out)
        else $error("channel two interrupt not raised");
    a_irq_two_clear: assert property (!(tx_below_trigger[1] || tx_empty[1] || rx_above_trigger[1]) |=> !channel_two_interrupt_out)
        else $error("channel two interrupt not cleared");
    a_read_drive: assert property (s_rd_held |-> !data_drive_n)
        else $error("read data not driven");
    a_bus_release: assert property (s_idle |-> data_drive_n)
        else $error("data bus driven while deselected");
    a_osc_echo: assert property (s_osc_still |-> oscillator_output == !oscillator_input)
        else $error("oscillator output not inverse of input");
    a_sample_gap: assert property (channel_one_sample_tick |=> !channel_one_sample_tick [*3])
        else $error("sample ticks too close");
    // the bit tick is registered off the sample tick that ends the bit, one clock later
    a_bit_on_sample: assert property (channel_one_bit_tick |-> $past(channel_one_sample_tick))
        else $error("bit tick without sample tick");
    a_bit_gap: assert property (channel_one_bit_tick |=> !channel_one_bit_tick [*8])
        else $error("bit ticks too close");
endmodule // fbr_chk

bind fbr_top fbr_chk u_chk (.clk, .rst, .chip_select_n, .read_strobe_n, .data_drive_n,
    .oscillator_input, .oscillator_output, .tx_below_trigger, .tx_empty, .rx_above_trigger,
    .channel_one_interrupt_out, .channel_two_interrupt_out, .channel_one_sample_tick,
    .channel_one_bit_tick);

// [tb/fbr_host.sv]
/* host processor model on the asynchronous register bus.
   assumes strobes of four clk low and four high satisfy the pin filter. */
`timescale 1ns/1ps
module fbr_host (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_drive_n,
    output logic            chip_select_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic            channel_select,
    output logic [2:0]      addr,
    output logic [7:0]      data_in
);
    initial begin
        {chip_select_n, read_strobe_n, write_strobe_n, channel_select} = 4'hf;
        addr = 3'h0;
        data_in = 8'h00;
    end
    // released address and data lines show the inverse of the last value, never a stale copy; channel select keeps its value
    task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        {channel_select, addr, data_in} = {ch, a, d};
        {chip_select_n, write_strobe_n} = 2'h0;
        repeat (4) @(negedge clk);
        write_strobe_n = 1'b1;
        repeat (4) @(negedge clk);
        chip_select_n = 1'b1;
        {addr, data_in} = {~a, ~d};
        repeat (4) @(negedge clk);
    endtask
    task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
        int g;
        g = 0;
        @(negedge clk);
        {channel_select, addr} = {ch, a};
        {chip_select_n, read_strobe_n} = 2'h0;
        while (data_drive_n !== 1'b0 && g < 20) begin
            @(negedge clk);
            g++;
        end
        d = (g < 20) ? data_out : 8'hxx;
        @(negedge clk);
        {chip_select_n, read_strobe_n} = 2'h3;
        addr = ~a;
        repeat (6) @(negedge clk);
    endtask
endmodule // fbr_host

// [tb/fbr_top_bench.sv]
/* self-checking bench: register reset and readback, sampling periods, interrupt pins.
   assumes fbr_host drives the bus; the bench drives oscillator and fifo flags. */
`timescale 1ns/1ps
module fbr_top_bench;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       osc = 1'b0;
    logic       osc_on = 1'b0;
    logic [1:0] tx_below = 2'h0;
    logic [1:0] tx_emp = 2'h0;
    logic [1:0] rx_above = 2'h0;
    logic [2:0] oc = 3'h0;
    logic [7:0] rv;
    wire        cs_n, rd_n, wr_n, chsel, drv_n, osc_out, irq1, irq2, st1, bt1, st2, bt2;
    wire  [2:0] addr;
    wire  [7:0] din, dout;
    int         errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         seed = 32'h9a5c;
    int         n, ch, p, k, i;

    fbr_top dut (.clk(clk), .rst(rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .channel_select(chsel), .addr(addr), .data_in(din),
        .data_out(dout), .data_drive_n(drv_n), .oscillator_input(osc), .oscillator_output(osc_out),
        .tx_below_trigger(tx_below), .tx_empty(tx_emp), .rx_above_trigger(rx_above),
        .channel_one_interrupt_out(irq1), .channel_two_interrupt_out(irq2),
        .channel_one_sample_tick(st1), .channel_one_bit_tick(bt1),
        .channel_two_sample_tick(st2), .channel_two_bit_tick(bt2));
    fbr_host host (.clk(clk), .data_out(dout), .data_drive_n(drv_n), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .channel_select(chsel), .addr(addr),
        .data_in(din));

    initial forever #2.5 clk = ~clk;
    // oscillator period ten clk, well inside the clk/4 limit of the pin filter
    always @(negedge clk) begin
        if (osc_on) begin
            oc <= (oc == 3'h4) ? 3'h0 : oc + 3'h1;
            if (oc == 3'h4) osc <= ~osc;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chk_pin(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    // sixteen sample periods always carry exactly f stretch ticks of the prescaled oscillator
    function automatic logic [31:0] exp_clks(int n, int f, int p);
        return 10 * (p ? 4 : 1) * (16 * (n == 0 ? 1 : n) + f);
    endfunction
    function automatic logic exp_irq(logic fe, logic b, logic e, logic a);
        return fe ? (b | e | a) : (e | a);
    endfunction
    task automatic span(input logic ch, input int bits, output int clks, output int samp);
        int g, b;
        {g, b, clks, samp} = 0;
        while (!(ch ? bt1 : bt2) && g < 20000) begin
            @(negedge clk);
            g++;
        end
        while (b < bits && g < 20000) begin
            @(negedge clk);
            {g, clks} = {g + 1, clks + 1};
            if (ch ? st1 : st2) samp++;
            if (ch ? bt1 : bt2) b++;
        end
    endtask
    task automatic run_case(input logic ch, input int n, input int f, input int m, input int p);
        int c, s;
        host.wr(ch, 3'h3, {p[0], 7'h00});
        host.wr(ch, 3'h0, n[7:0]);
        host.wr(ch, 3'h1, n[15:8]);
        host.wr(ch, 3'h2, {2'h0, m[1:0], f[3:0]});
        span(ch, 1, c, s);
        span(ch, 1, c, s);
        span(ch, (m == 1) ? 2 : (m == 2) ? 4 : 1, c, s);
        chk_val("period", exp_clks(n, f, p), c);
        chk_val("samples", 16, s);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        for (ch = 0; ch < 2; ch++) begin
            for (k = 0; k < 7; k++) begin
                host.rd(ch[0], k[2:0], rv);
                chk_val("reset reg", (k == 0) ? 1 : 0, rv);
            end
            n = $random(seed);
            host.wr(ch[0], 3'h0, n[7:0] | 8'h01);
            host.wr(ch[0], 3'h1, n[15:8]);
            host.wr(ch[0], 3'h2, 8'hff);
            host.wr(ch[0], 3'h7, 8'h5a);
            host.rd(ch[0], 3'h0, rv);
            chk_val("div low", n[7:0] | 8'h01, rv);
            host.rd(ch[0], 3'h1, rv);
            chk_val("div high", n[15:8], rv);
            host.rd(ch[0], 3'h2, rv);
            chk_val("fraction", 8'h3f, rv);
            host.rd(ch[0], 3'h7, rv);
            chk_val("unmapped", 8'h00, rv);
            // zero integer divisor exposes the id codes (arbitrary design defaults)
            host.wr(ch[0], 3'h0, 8'h00);
            host.wr(ch[0], 3'h1, 8'h00);
            host.rd(ch[0], 3'h0, rv);
            chk_val("revision id", 8'h01, rv);
            host.rd(ch[0], 3'h1, rv);
            chk_val("device id", 8'h5a, rv);
        end
        osc_on = 1'b1;
        run_case(1'b1, 0, 0, 3, 0);
        run_case(1'b0, 1, 15, 1, 1);
        run_case(1'b1, 2, 7, 2, 0);
        run_case(1'b0, 3, 9, 0, 1);
        repeat (3) run_case($random(seed) & 1, $random(seed) & 3, $random(seed) & 15,
            $random(seed) & 3, $random(seed) & 1);
        for (ch = 0; ch < 2; ch++) begin
            for (p = 0; p < 2; p++) begin
                host.wr(ch[0], 3'h4, p[7:0]);
                i = ch ? 0 : 1;
                repeat (8) begin
                    k = $random(seed);
                    @(negedge clk);
                    {tx_below, tx_emp, rx_above} = k[5:0];
                    @(negedge clk);
                    chk_pin("interrupt", exp_irq(p[0], tx_below[i], tx_emp[i], rx_above[i]),
                        ch ? irq1 : irq2);
                end
            end
        end
        print_verdict();
    end
endmodule // fbr_top_bench
